// ---- design/hdlc_dma_chan.sv ----
// hdlc dma: receive channel state, indirect config access and transmit queueing
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// [RULE1] first-fill flag steers mixed buffer size switch
// [RULE2] 13-bit byte count, capped at 8188
// [RULE3] 3-bit buffer count compared with threshold
// [RULE4] select low byte is the channel number
// [RULE5] word select picks halfword; 110/111 illegal
// [RULE6] host writes only lower half dword 2
// [RULE7] indirect read: busy until data register loaded
// [RULE8] indirect write: copy data, busy until done
// [RULE9] host polls busy before next access
// [RULE10] data register holds sixteen config bits
// [RULE11] host sizes buffers 1 to 8188 bytes
// [RULE12] end-of-frame zero follows next descriptor pointer
// [RULE13] chain-valid honoured only at end-of-frame
// [RULE14] two chains inside, further ones linked out
// [RULE15] priority starts after current standard packet
// [RULE16] all priority traffic before further standard
// [RULE17] priority chains served first come first
// [RULE18] resume standard chain with its next packet
// [RULE19] host posts pending descriptors for ready channels
// [RULE20] post done descriptor per packet or buffer
// [RULE21] burst mode for pending and done queues
// [RULE22] per-channel select: packet or buffer completion
// [RULE23] errors disable channel and post error status
// [RULE24] threshold 1..7 buffers, zero means packet end
// [RULE25] mixed size: one small buffer then large
module hdlc_dma_chan
  import hdlc_dma_pkg::*;
#(
  parameter int NUM_CH = 256
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_ev_i,
  input  wire logic [7:0]  rx_ch_i,
  input  wire logic        rx_new_buf_i,
  input  wire logic        rx_pkt_start_i,
  input  wire logic [31:0] rx_buf_addr_i,
  input  wire logic [15:0] rx_desc_i,
  input  wire logic [12:0] rx_bytes_i,
  input  wire logic        rx_buf_full_i,
  input  wire logic        rx_pkt_end_i,
  output logic             rx_post_o,
  output logic      [7:0]  rx_post_ch_o,
  output logic             rx_use_large_o,
  output logic             rx_chan_en_o,
  input  wire logic        pq_valid_i,
  output logic             pq_ready_o,
  input  wire logic [15:0] pq_ptr_i,
  input  wire logic [7:0]  pq_chan_i,
  input  wire logic        pq_pri_i,
  output logic             desc_rd_o,
  output logic      [15:0] desc_ptr_o,
  input  wire logic        desc_ack_i,
  input  wire logic        desc_bus_err_i,
  input  wire logic        desc_eof_i,
  input  wire logic        desc_cv_i,
  input  wire logic [12:0] desc_bytes_i,
  input  wire logic [15:0] desc_next_i,
  input  wire logic [7:0]  desc_chan_i,
  input  wire logic        desc_pv_i,
  input  wire logic [15:0] desc_npend_i,
  output logic             xmit_req_o,
  output logic      [7:0]  xmit_chan_o,
  output logic      [12:0] xmit_bytes_o,
  input  wire logic        xmit_done_i,
  input  wire logic        xmit_underflow_i,
  output logic             link_wr_o,
  output logic      [15:0] link_ptr_o,
  output logic      [15:0] link_data_o,
  input  wire logic        link_ack_i,
  output logic             dq_wr_o,
  output logic      [15:0] dq_ptr_o,
  output logic      [7:0]  dq_chan_o,
  output logic      [2:0]  dq_status_o,
  input  wire logic        dq_ack_i,
  output logic             burst_en_o
);
  if (NUM_CH < 1 || NUM_CH > 256) begin : g_chk
    $error("NUM_CH must lie between 1 and 256");
  end

  // receive configuration ram, one entry per channel and halfword group
  logic [31:0] rx_addr_q  [NUM_CH];
  logic [15:0] rx_cdesc_q [NUM_CH];
  logic [15:0] rx_sdesc_q [NUM_CH];
  logic [15:0] rx_lo_q    [NUM_CH];
  logic [15:0] rx_hi_q    [NUM_CH];
  logic [NUM_CH-1:0] tx_en_q;
  logic [NUM_CH-1:0] tx_dqs_q;

  logic [15:0] sel_q, data_q;
  logic        busy_q, ack_q, burst_q;
  logic [7:0]  txc_ch_q;
  logic [15:0] wmask;
  logic        bus_req, wr_sel, wr_data, wr_txc, wr_ctrl, ind_start;
  logic [7:0]  ind_ch;
  logic [2:0]  ind_ws;

  assign bus_req   = wb_cyc_i && wb_stb_i && !ack_q && ce_i;
  assign wmask     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr_sel    = bus_req && wb_we_i && wb_adr_i == RX_SEL_OFS;
  assign wr_data   = bus_req && wb_we_i && wb_adr_i == RX_DATA_OFS && !busy_q;
  assign wr_txc    = bus_req && wb_we_i && wb_adr_i == TX_CHAN_OFS;
  assign wr_ctrl   = bus_req && wb_we_i && wb_adr_i == TX_CTRL_OFS && wb_sel_i[0];
  // a new access while busy is dropped; software waits for busy low
  assign ind_start = wr_sel && wb_sel_i[1] && !busy_q; // [RULE9]
  assign ind_ch    = sel_q[7:0]; // [RULE4]
  assign ind_ws    = sel_q[SEL_WS_LSB+:3];

  // bus slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end
  assign wb_ack_o = ack_q;

  logic [3:0] st_bits;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      case (wb_adr_i)
        RX_SEL_OFS:  wb_dat_o <= {16'h0000, busy_q, sel_q[14:0]};
        RX_DATA_OFS: wb_dat_o <= {16'h0000, data_q}; // [RULE10]
        TX_CHAN_OFS: wb_dat_o <= {22'h000000, tx_dqs_q[txc_ch_q], tx_en_q[txc_ch_q], txc_ch_q};
        TX_CTRL_OFS: wb_dat_o <= {31'h00000000, burst_q};
        TX_STAT_OFS: wb_dat_o <= {28'h0000000, st_bits};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // indirect select register; busy is one access cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q  <= SEL_RST;
      busy_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_sel && !busy_q) begin
        sel_q <= (sel_q & ~(wmask & SEL_WR_MASK)) | (wb_dat_i[15:0] & wmask & SEL_WR_MASK);
      end
      busy_q <= ind_start; // [RULE7] [RULE8]
    end
  end

  // data register: loaded by host, or by an indirect read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= DATA_RST;
    end else if (ce_i) begin
      if (busy_q && sel_q[SEL_RW_BIT]) begin
        case (ind_ws) // [RULE5] [RULE7]
          WS_D0_LO: data_q <= rx_addr_q[ind_ch][15:0];
          WS_D0_HI: data_q <= rx_addr_q[ind_ch][31:16];
          WS_D1_LO: data_q <= rx_cdesc_q[ind_ch];
          WS_D1_HI: data_q <= rx_sdesc_q[ind_ch];
          WS_D2_LO: data_q <= rx_lo_q[ind_ch];
          WS_D2_HI: data_q <= rx_hi_q[ind_ch];
          default:  data_q <= 16'h0000;
        endcase
      end else if (wr_data) begin
        data_q <= (data_q & ~wmask) | (wb_dat_i[15:0] & wmask);
      end
    end
  end

  // receive dma working state
  logic [15:0] ev_lo, ev_hi;
  logic [12:0] bc_base;
  logic [13:0] bc_sum;
  logic [12:0] bc_n;
  logic [2:0]  tcnt_n, thr, tc_base;
  logic        closed, post_n, fbf_n;
  assign ev_lo   = rx_lo_q[rx_ch_i];
  assign ev_hi   = rx_hi_q[rx_ch_i];
  assign thr     = ev_lo[CFG_THR_LSB+:3];
  assign closed  = rx_buf_full_i || rx_pkt_end_i;
  assign bc_base = rx_new_buf_i ? 13'h0000 : ev_hi[12:0];
  assign bc_sum  = {1'b0, bc_base} + {1'b0, rx_bytes_i};
  assign bc_n    = (bc_sum > {1'b0, BYTE_MAX}) ? BYTE_MAX : bc_sum[12:0]; // [RULE2]
  // a new packet restarts the buffer count; ram words are not reset
  assign tc_base = rx_pkt_start_i ? 3'h0 : ev_hi[HI_TCNT_LSB+:3];
  assign tcnt_n  = (closed && tc_base != TCNT_MAX) ? tc_base + 3'h1 : tc_base;
  assign post_n  = rx_pkt_end_i || (closed && thr != 3'h0 && tcnt_n >= thr); // [RULE3] [RULE24]
  // first buffer flag stays up until that buffer closes
  assign fbf_n   = closed ? 1'b0 : (rx_pkt_start_i || ev_lo[CFG_FBF_BIT]); // [RULE1]

  always_ff @(posedge clk_i) begin
    if (ce_i && rx_ev_i && rx_new_buf_i) begin
      rx_addr_q[rx_ch_i]  <= rx_buf_addr_i;
      rx_cdesc_q[rx_ch_i] <= rx_desc_i;
      if (rx_pkt_start_i) begin
        rx_sdesc_q[rx_ch_i] <= rx_desc_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && rx_ev_i) begin
      rx_hi_q[rx_ch_i] <= {post_n ? 3'h0 : tcnt_n, bc_n}; // [RULE2] [RULE3]
    end
  end

  // host bits and dma flag share a word; each side keeps its own bits
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (busy_q && !sel_q[SEL_RW_BIT] && ind_ws == WS_D2_LO) begin
        rx_lo_q[ind_ch] <= (rx_lo_q[ind_ch] & ~CFG_HOST_MASK) | (data_q & CFG_HOST_MASK); // [RULE6] [RULE8]
      end
      if (rx_ev_i) begin
        rx_lo_q[rx_ch_i][CFG_FBF_BIT] <= fbf_n; // [RULE1]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_post_o      <= 1'b0;
      rx_post_ch_o   <= 8'h00;
      rx_use_large_o <= 1'b0;
      rx_chan_en_o   <= 1'b0;
    end else if (ce_i) begin
      rx_post_o <= rx_ev_i && post_n;
      if (rx_ev_i) begin
        rx_post_ch_o <= rx_ch_i;
        rx_chan_en_o <= ev_lo[CFG_EN_BIT];
        case (ev_lo[CFG_SIZE_LSB+:2])
          SIZE_LARGE: rx_use_large_o <= 1'b1;
          SIZE_MIXED: rx_use_large_o <= !fbf_n && !rx_pkt_end_i; // [RULE25]
          default:    rx_use_large_o <= 1'b0;
        endcase
      end
    end
  end

  // transmit queueing: slot 0 standard chain, slot 1 priority chain
  tx_state_t st_q;
  logic [1:0]  act_q, first_q, chk_q, extv_q, tint_q;
  logic [15:0] nxt_q [2];
  logic [15:0] ext_q [2];
  logic [15:0] tail_q [2];
  logic [7:0]  chan_q [2];
  logic        cls_q, mid_q, pfirst_q, lnk_q;
  logic [15:0] d_ptr_q, d_next_q;
  logic        d_eof_q, d_cv_q;
  logic [7:0]  d_chan_q;
  logic [12:0] d_bytes_q;
  logic [2:0]  stat_q;
  logic        take, pc, dq_sel, fetch_ok, xdone;
  logic [7:0]  f_chan;
  logic [2:0]  f_err;

  assign pq_ready_o = (st_q == TX_IDLE || st_q == TX_XMIT) && !lnk_q;
  assign take       = pq_valid_i && pq_ready_o && ce_i;
  assign pc         = pq_pri_i;
  assign fetch_ok   = st_q == TX_FETCH && desc_ack_i && ce_i;
  assign xdone      = st_q == TX_XMIT && xmit_done_i && ce_i;
  assign f_chan     = (first_q[cls_q] && chk_q[cls_q]) ? chan_q[cls_q] : desc_chan_i;
  assign dq_sel     = tx_dqs_q[d_chan_q];
  assign st_bits    = {lnk_q, cls_q, act_q};

  always_comb begin
    f_err = ST_PKT_OK;
    if (desc_bus_err_i) begin
      f_err = ST_ERR_BUS; // [RULE23]
    end else if (!tx_en_q[f_chan]) begin
      f_err = ST_ERR_DIS; // [RULE23]
    end else if (desc_bytes_i == 13'h0000 || f_chan != desc_chan_i) begin
      f_err = ST_ERR_DESC; // [RULE23]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= TX_IDLE;
      cls_q    <= 1'b0;
      mid_q    <= 1'b0;
      pfirst_q <= 1'b1;
      stat_q   <= ST_PKT_OK;
    end else if (ce_i) begin
      case (st_q)
        TX_IDLE: begin
          if (mid_q) begin
            st_q <= TX_FETCH; // [RULE12]
          end else if (act_q[1]) begin
            cls_q <= 1'b1; // [RULE15] [RULE16]
            st_q  <= TX_FETCH;
          end else if (act_q[0]) begin
            cls_q <= 1'b0; // [RULE18]
            st_q  <= TX_FETCH;
          end
        end
        TX_FETCH: begin
          if (desc_ack_i) begin
            stat_q <= f_err;
            st_q   <= (f_err != ST_PKT_OK) ? TX_POST : TX_XMIT;
          end
        end
        TX_XMIT: begin
          if (xmit_done_i) begin
            if (xmit_underflow_i) begin
              stat_q <= ST_ERR_UFL; // [RULE23]
              st_q   <= TX_POST;
            end else if (dq_sel) begin
              stat_q <= !d_eof_q ? (pfirst_q ? ST_BUF_FIRST : ST_BUF_MID) : ST_BUF_LAST;
              st_q   <= TX_POST; // [RULE22]
            end else begin
              stat_q <= ST_PKT_OK;
              st_q   <= d_eof_q ? TX_POST : TX_ADV; // [RULE20] [RULE22]
            end
          end
        end
        TX_POST: begin
          if (dq_ack_i) begin
            st_q <= TX_ADV;
          end
        end
        TX_ADV: begin
          mid_q    <= !d_eof_q;
          pfirst_q <= d_eof_q;
          st_q     <= TX_IDLE;
        end
        default: st_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      d_ptr_q   <= 16'h0000;
      d_next_q  <= 16'h0000;
      d_eof_q   <= 1'b0;
      d_cv_q    <= 1'b0;
      d_chan_q  <= 8'h00;
      d_bytes_q <= 13'h0000;
    end else if (ce_i) begin
      if (st_q == TX_IDLE) begin
        d_ptr_q <= mid_q ? nxt_q[cls_q] : (act_q[1] ? nxt_q[1] : nxt_q[0]);
      end
      if (fetch_ok) begin
        d_next_q  <= desc_next_i;
        d_eof_q   <= desc_eof_i;
        d_cv_q    <= desc_cv_i;
        d_chan_q  <= f_chan;
        d_bytes_q <= desc_bytes_i;
      end
    end
  end

  // chain slots; arrivals only in idle or transmit, so no clash with advance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_q   <= 2'b00;
      first_q <= 2'b00;
      chk_q   <= 2'b00;
      extv_q  <= 2'b00;
      tint_q  <= 2'b00;
      for (int c = 0; c < 2; c++) begin
        nxt_q[c]  <= 16'h0000;
        ext_q[c]  <= 16'h0000;
        tail_q[c] <= 16'h0000;
        chan_q[c] <= 8'h00;
      end
    end else if (ce_i) begin
      if (take) begin
        tail_q[pc] <= pq_ptr_i; // [RULE17]
        if (!act_q[pc]) begin
          act_q[pc]   <= 1'b1;
          nxt_q[pc]   <= pq_ptr_i;
          first_q[pc] <= 1'b1;
          chk_q[pc]   <= 1'b1;
          chan_q[pc]  <= pq_chan_i;
          tint_q[pc]  <= 1'b1;
          extv_q[pc]  <= 1'b0;
        end else begin
          tint_q[pc] <= 1'b0; // [RULE14]
          if (tint_q[pc] && !extv_q[pc]) begin
            extv_q[pc] <= 1'b1;
            ext_q[pc]  <= pq_ptr_i;
          end
        end
      end
      if (fetch_ok && first_q[cls_q]) begin
        first_q[cls_q] <= 1'b0;
        if (desc_pv_i && !extv_q[cls_q]) begin
          extv_q[cls_q] <= 1'b1; // [RULE14]
          ext_q[cls_q]  <= desc_npend_i;
        end
      end
      if (st_q == TX_ADV) begin
        if (!d_eof_q || d_cv_q) begin
          nxt_q[cls_q] <= d_next_q; // [RULE12] [RULE13]
        end else if (extv_q[cls_q]) begin
          nxt_q[cls_q]   <= ext_q[cls_q]; // [RULE14] [RULE17]
          first_q[cls_q] <= 1'b1;
          chk_q[cls_q]   <= 1'b0;
          extv_q[cls_q]  <= 1'b0;
          tint_q[cls_q]  <= tail_q[cls_q] == ext_q[cls_q];
        end else begin
          act_q[cls_q] <= 1'b0;
        end
      end
    end
  end

  // external link write into the previous chain head
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lnk_q       <= 1'b0;
      link_ptr_o  <= 16'h0000;
      link_data_o <= 16'h0000;
    end else if (ce_i) begin
      if (take && act_q[pc]) begin
        lnk_q       <= 1'b1; // [RULE14]
        link_ptr_o  <= tail_q[pc];
        link_data_o <= pq_ptr_i;
      end else if (link_ack_i) begin
        lnk_q <= 1'b0;
      end
    end
  end

  // channel enables: errors clear, host apply writes last
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_en_q  <= '0;
      tx_dqs_q <= '0;
      txc_ch_q <= 8'h00;
      burst_q  <= BURST_RST;
    end else if (ce_i) begin
      if ((fetch_ok && f_err != ST_PKT_OK) || (xdone && xmit_underflow_i)) begin
        tx_en_q[fetch_ok ? f_chan : d_chan_q] <= 1'b0; // [RULE23]
      end
      if (wr_txc && wb_sel_i[0]) begin
        txc_ch_q <= wb_dat_i[7:0];
      end
      if (wr_txc && wb_sel_i[1] && wb_dat_i[TXC_APPLY_BIT]) begin
        tx_en_q[wb_dat_i[7:0]]  <= wb_dat_i[TXC_EN_BIT];
        tx_dqs_q[wb_dat_i[7:0]] <= wb_dat_i[TXC_DQS_BIT]; // [RULE22]
      end
      if (wr_ctrl) begin
        burst_q <= wb_dat_i[0]; // [RULE21]
      end
    end
  end

  assign burst_en_o   = burst_q; // [RULE21]
  assign desc_rd_o    = st_q == TX_FETCH;
  assign desc_ptr_o   = d_ptr_q;
  assign xmit_req_o   = st_q == TX_XMIT;
  assign xmit_chan_o  = d_chan_q;
  assign xmit_bytes_o = d_bytes_q;
  assign link_wr_o    = lnk_q;
  assign dq_wr_o      = st_q == TX_POST; // [RULE20]
  assign dq_ptr_o     = d_ptr_q;
  assign dq_chan_o    = d_chan_q;
  assign dq_status_o  = stat_q;
endmodule // hdlc_dma_chan

// ---- design/hdlc_dma_pkg.sv ----
// package: register map, field layout and codes of the hdlc dma channel block
package hdlc_dma_pkg;
  // register byte offsets
  localparam logic [11:0] RX_SEL_OFS   = 12'h770;
  localparam logic [11:0] RX_DATA_OFS  = 12'h774;
  localparam logic [11:0] TX_CHAN_OFS  = 12'h7c0;
  localparam logic [11:0] TX_CTRL_OFS  = 12'h7c4;
  localparam logic [11:0] TX_STAT_OFS  = 12'h7c8;
  // reset values
  localparam logic [15:0] SEL_RST      = 16'h0000;
  localparam logic [15:0] DATA_RST     = 16'h0000;
  localparam logic        BURST_RST    = 1'b0;
  // indirect select fields
  localparam int          SEL_WS_LSB   = 8;
  localparam int          SEL_RW_BIT   = 14;
  localparam int          SEL_BUSY_BIT = 15;
  localparam logic [15:0] SEL_WR_MASK  = 16'h47ff;
  // word select codes
  localparam logic [2:0]  WS_D0_LO     = 3'h0;
  localparam logic [2:0]  WS_D0_HI     = 3'h1;
  localparam logic [2:0]  WS_D1_LO     = 3'h2;
  localparam logic [2:0]  WS_D1_HI     = 3'h3;
  localparam logic [2:0]  WS_D2_LO     = 3'h4;
  localparam logic [2:0]  WS_D2_HI     = 3'h5;
  // dword 2 lower half
  localparam int          CFG_EN_BIT   = 0;
  localparam int          CFG_SIZE_LSB = 1;
  localparam int          CFG_THR_LSB  = 7;
  localparam int          CFG_FBF_BIT  = 15;
  localparam logic [15:0] CFG_HOST_MASK = 16'h0387;
  localparam logic [1:0]  SIZE_LARGE   = 2'h0;
  localparam logic [1:0]  SIZE_SMALL   = 2'h1;
  localparam logic [1:0]  SIZE_MIXED   = 2'h2;
  // dword 2 upper half
  localparam int          HI_TCNT_LSB  = 13;
  localparam logic [12:0] BYTE_MAX     = 13'h1ffc;
  localparam logic [2:0]  TCNT_MAX     = 3'h7;
  // transmit channel control fields
  localparam int          TXC_EN_BIT   = 8;
  localparam int          TXC_DQS_BIT  = 9;
  localparam int          TXC_APPLY_BIT = 15;
  // done-queue status codes
  localparam logic [2:0]  ST_PKT_OK    = 3'h0;
  localparam logic [2:0]  ST_BUF_FIRST = 3'h1;
  localparam logic [2:0]  ST_BUF_MID   = 3'h2;
  localparam logic [2:0]  ST_BUF_LAST  = 3'h3;
  localparam logic [2:0]  ST_ERR_DIS   = 3'h4;
  localparam logic [2:0]  ST_ERR_DESC  = 3'h5;
  localparam logic [2:0]  ST_ERR_BUS   = 3'h6;
  localparam logic [2:0]  ST_ERR_UFL   = 3'h7;

  typedef enum logic [2:0] {TX_IDLE, TX_FETCH, TX_XMIT, TX_POST, TX_ADV} tx_state_t;
endpackage

// ---- test/hdlc_dma_chan_properties.sv ----
// concurrent checks on the hdlc dma channel block ports
`timescale 1ns/1ns
module hdlc_dma_chan_properties
  import hdlc_dma_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        rx_ev_i,
  input  wire logic        rx_post_o,
  input  wire logic        desc_rd_o,
  input  wire logic [15:0] desc_ptr_o,
  input  wire logic        desc_ack_i,
  input  wire logic        xmit_req_o,
  input  wire logic [12:0] xmit_bytes_o,
  input  wire logic        xmit_done_i,
  input  wire logic        dq_wr_o,
  input  wire logic [2:0]  dq_status_o,
  input  wire logic        dq_ack_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic mapped;
  assign mapped = wb_adr_i inside {RX_SEL_OFS, RX_DATA_OFS, TX_CHAN_OFS, TX_CTRL_OFS, TX_STAT_OFS};
  a_ack_one_wait: assert property (
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus ack late");
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("bus ack longer than one cycle");
  a_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_post_cause: assert property (
    rx_post_o |-> $past(rx_ev_i)) else $error("post without receive event");
  a_desc_hold: assert property (
    desc_rd_o && !desc_ack_i |=> desc_rd_o && $stable(desc_ptr_o)) else $error("fetch dropped");
  a_xmit_cause: assert property (
    $rose(xmit_req_o) |-> $past(desc_ack_i)) else $error("send without descriptor");
  a_xmit_hold: assert property (
    xmit_req_o && !xmit_done_i |=> xmit_req_o && $stable(xmit_bytes_o))
    else $error("send request dropped");
  a_dq_hold: assert property (
    dq_wr_o && !dq_ack_i |=> dq_wr_o && $stable(dq_status_o)) else $error("done post dropped");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_post: cover property (rx_post_o);
  c_done: cover property (dq_wr_o && dq_ack_i);
endmodule // hdlc_dma_chan_properties

bind hdlc_dma_chan hdlc_dma_chan_properties chk_u (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .rx_ev_i, .rx_post_o, .desc_rd_o, .desc_ptr_o,
  .desc_ack_i, .xmit_req_o, .xmit_bytes_o, .xmit_done_i, .dq_wr_o, .dq_status_o, .dq_ack_i);

// ---- test/hdlc_dma_chan_tb.sv ----
// self-checking bench for the hdlc dma channel block
`timescale 1ns/1ns
module hdlc_dma_chan_tb
  import hdlc_dma_pkg::*;
;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, p;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rx_buf_addr_i, q;
  logic rx_ev_i, rx_new_buf_i, rx_pkt_start_i, rx_buf_full_i, rx_pkt_end_i;
  logic rx_post_o, rx_use_large_o, rx_chan_en_o, pq_valid_i, pq_ready_o, pq_pri_i;
  logic [7:0] rx_ch_i, rx_post_ch_o, pq_chan_i, desc_chan_i, xmit_chan_o, dq_chan_o;
  logic [15:0] rx_desc_i, pq_ptr_i, desc_ptr_o, desc_next_i, desc_npend_i;
  logic [15:0] link_ptr_o, link_data_o, dq_ptr_o;
  logic [12:0] rx_bytes_i, desc_bytes_i, xmit_bytes_o;
  logic desc_rd_o, desc_ack_i, desc_bus_err_i, desc_eof_i, desc_cv_i, desc_pv_i;
  logic xmit_req_o, xmit_done_i, xmit_underflow_i, link_wr_o, link_ack_i, dq_wr_o, dq_ack_i;
  logic burst_en_o;
  logic [2:0] dq_status_o;
  logic [18:0] dq_q [$];
  logic [18:0] exp_dq [7] = '{{16'h1, ST_BUF_FIRST}, {16'h2, ST_BUF_LAST}, {16'h3, ST_BUF_LAST},
    {16'h6, ST_PKT_OK}, {16'h8, ST_PKT_OK}, {16'h7, ST_PKT_OK}, {16'h4, ST_ERR_DIS}};
  int err_total, checked;

  hdlc_dma_chan dut_u (.*);
  hdlc_dma_mem_model mdl_u (.clk_i, .desc_rd_o, .desc_ptr_o, .xmit_req_o, .dq_wr_o, .link_wr_o,
    .desc_ack_i, .desc_eof_i, .desc_cv_i, .desc_bytes_i, .desc_next_i, .desc_chan_i,
    .xmit_done_i, .dq_ack_i, .link_ack_i);

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (dq_wr_o && dq_ack_i) dq_q.push_back({dq_ptr_o, dq_status_o});

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // data taken at the ack edge
  task automatic wb(input logic we, input logic [11:0] a, input logic [15:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'h3, 16'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic ind(input logic rw, input logic [2:0] w, input logic [7:0] c);
    wb(1'b1, RX_SEL_OFS, {1'b0, rw, 3'h0, w, c});
    do wb(1'b0, RX_SEL_OFS, 16'h0000); while (q[SEL_BUSY_BIT] !== 1'b0);
    wb(1'b0, RX_DATA_OFS, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] c, input logic [2:0] w, input logic [15:0] d);
    wb(1'b1, RX_DATA_OFS, d);
    ind(1'b0, w, c);
  endtask
  // flags: 8 new buffer, 4 packet start, 2 buffer full, 1 packet end
  task automatic rx(input logic [7:0] c, input logic [3:0] f, input logic [12:0] b);
    {rx_ch_i, rx_new_buf_i, rx_pkt_start_i, rx_buf_full_i, rx_pkt_end_i, rx_bytes_i} <= {c, f, b};
    {rx_desc_i, rx_buf_addr_i, rx_ev_i} <= {3'h0, b, 19'h0, b, 1'b1};
    @(posedge clk_i);
    rx_ev_i <= 1'b0;
    @(posedge clk_i);
    p = rx_post_o;
  endtask
  task automatic push(input logic [15:0] a, input logic [7:0] c, input logic r);
    {pq_ptr_i, pq_chan_i, pq_pri_i, pq_valid_i} <= {a, c, r, 1'b1};
    do @(posedge clk_i); while (pq_ready_o !== 1'b1);
    pq_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {rst_i, ce_i} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, rx_ev_i, rx_ch_i, rx_new_buf_i,
     rx_pkt_start_i, rx_buf_addr_i, rx_desc_i, rx_bytes_i, rx_buf_full_i, rx_pkt_end_i,
     pq_valid_i, pq_ptr_i, pq_chan_i, pq_pri_i, desc_bus_err_i, desc_pv_i, desc_npend_i,
     xmit_underflow_i} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, RX_SEL_OFS, 16'h0000);
    chk(q, {16'h0, SEL_RST});
    wb(1'b0, 12'h7fc, 16'h0000);
    chk(q, 32'h0);
    wb(1'b1, TX_CTRL_OFS, 16'h0001);
    chk(burst_en_o, 1'b1);
    $display("test registers done");
    wr(8'hff, WS_D2_LO, 16'hfc85);
    wr(8'h04, WS_D2_LO, 16'h0001);
    ind(1'b1, WS_D2_LO, 8'hff);
    chk(q & {16'h0, CFG_HOST_MASK}, 32'h85);
    rx(8'hff, 4'hc, 13'h0);
    ind(1'b1, WS_D2_LO, 8'hff);
    chk(q[CFG_FBF_BIT], 1'b1);
    rx(8'hff, 4'h0, 13'd8000);
    rx(8'hff, 4'h0, 13'd8000);
    wr(8'hff, WS_D2_HI, 16'h0000);
    ind(1'b1, WS_D2_HI, 8'hff);
    chk(q, {19'h0, BYTE_MAX});
    rx(8'hff, 4'h2, 13'h0);
    chk({p, rx_use_large_o, rx_post_ch_o}, {2'b11, 8'hff});
    ind(1'b1, WS_D2_LO, 8'hff);
    chk(q[CFG_FBF_BIT], 1'b0);
    ind(1'b1, 3'h6, 8'hff);
    chk(q, 32'h0);
    rx(8'h04, 4'hc, 13'd10);
    rx(8'h04, 4'h2, 13'h0);
    chk(p, 1'b0);
    ind(1'b1, WS_D2_HI, 8'h04);
    chk(q, 32'h200a);
    rx(8'h04, 4'h1, 13'h0);
    chk(p, 1'b1);
    $display("test receive done");
    wb(1'b1, TX_CHAN_OFS, 16'h8303);
    push(16'h1, 8'h3, 1'b0);
    while (dq_q.size() < 3) @(posedge clk_i);
    wb(1'b1, TX_CHAN_OFS, 16'h8103);
    push(16'h6, 8'h3, 1'b0);
    push(16'h8, 8'h3, 1'b1);
    while (dq_q.size() < 6) @(posedge clk_i);
    push(16'h4, 8'h4, 1'b0);
    while (dq_q.size() < 7) @(posedge clk_i);
    foreach (exp_dq[i]) chk(dq_q[i], exp_dq[i]);
    $display("test transmit done");
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    conclude();
  end
endmodule // hdlc_dma_chan_tb

// ---- test/hdlc_dma_mem_model.sv ----
// host memory, transmitter and done-queue responder model
`timescale 1ns/1ns
module hdlc_dma_mem_model (
  input  wire logic        clk_i,
  input  wire logic        desc_rd_o,
  input  wire logic [15:0] desc_ptr_o,
  input  wire logic        xmit_req_o,
  input  wire logic        dq_wr_o,
  input  wire logic        link_wr_o,
  output logic             desc_ack_i,
  output logic             desc_eof_i,
  output logic             desc_cv_i,
  output logic      [12:0] desc_bytes_i,
  output logic      [15:0] desc_next_i,
  output logic      [7:0]  desc_chan_i,
  output logic             xmit_done_i,
  output logic             dq_ack_i,
  output logic             link_ack_i
);
  logic [38:0] mem [16];
  logic [38:0] d;
  logic [1:0]  slow_q;
  assign d = mem[desc_ptr_o[3:0]];
  // stale fields are inverted so a late sample cannot match
  assign {desc_eof_i, desc_cv_i, desc_bytes_i, desc_next_i, desc_chan_i} = desc_ack_i ? d : ~d;
  initial begin
    {desc_ack_i, xmit_done_i, dq_ack_i, link_ack_i, slow_q} = '0;
    mem[1] = {2'b01, 13'd100, 16'h2, 8'h3};
    mem[2] = {2'b11, 13'd1, 16'h3, 8'h3};
    mem[3] = {2'b10, 13'd8188, 16'h0, 8'h3};
    mem[4] = {2'b10, 13'd9, 16'h0, 8'h4};
    mem[6] = {2'b11, 13'd9, 16'h7, 8'h3};
    mem[7] = {2'b10, 13'd9, 16'h0, 8'h3};
    mem[8] = {2'b10, 13'd9, 16'h0, 8'h3};
  end
  // alternate prompt and slow answers
  always @(posedge clk_i) begin
    slow_q <= slow_q + 2'h1;
    desc_ack_i <= desc_rd_o && !desc_ack_i && slow_q[0];
    xmit_done_i <= xmit_req_o && !xmit_done_i && slow_q[1];
    dq_ack_i <= dq_wr_o && !dq_ack_i;
    link_ack_i <= link_wr_o && !link_ack_i;
  end
endmodule // hdlc_dma_mem_model
